// ==== rtl/ivr_pkg.sv ====
// package for the interrupt vector and reset status unit
// assumes a 32-bit AHB-Lite bus and one clock domain
package ivr_pkg;

    // ==========================================================
    // register indices, byte address is four times the index
    // ==========================================================
    localparam logic [15:0] IVR_IDX_BREAK_STATUS = 16'hFE00;
    localparam logic [15:0] IVR_IDX_RESET_CAUSE = 16'hFE01;
    localparam logic [15:0] IVR_IDX_BREAK_FLAG_CTRL = 16'hFE03;
    localparam logic [15:0] IVR_IDX_PEND_LOW = 16'hFE04;
    localparam logic [15:0] IVR_IDX_PEND_HIGH = 16'hFE05;

    // ==========================================================
    // field positions
    // ==========================================================
    localparam int IVR_BIT_BREAK_WAIT = 1;
    localparam int IVR_BIT_CLEAR_ENABLE = 7;
    localparam int IVR_BIT_POWER_ON = 7;
    localparam int IVR_BIT_PIN = 6;
    localparam int IVR_BIT_WATCHDOG = 5;
    localparam int IVR_BIT_ILL_OPCODE = 4;
    localparam int IVR_BIT_ILL_ADDRESS = 3;
    localparam int IVR_BIT_MODE_ENTRY = 2;
    localparam int IVR_BIT_LOW_VOLTAGE = 1;

    // ==========================================================
    // reset values
    // ==========================================================
    localparam logic [7:0] IVR_RST_RESET_CAUSE = 8'h80;
    localparam logic [7:0] IVR_RST_PEND = 8'h00;
    localparam logic [7:0] IVR_RST_BREAK = 8'h00;

    // ==========================================================
    // interrupt sources and vector map
    // ==========================================================
    localparam int IVR_NUM_SRC = 21;
    localparam logic [15:0] IVR_VEC_RESET = 16'hFFFE;
    localparam logic [15:0] IVR_VEC_SWI = 16'hFFFC;
    localparam logic [15:0] IVR_VEC_FLAG_BASE = 16'hFFFC;
    localparam logic [15:0] IVR_VEC_IDLE = 16'h0000;

    // kind of vector being presented
    typedef enum logic [1:0] {
        IVR_VK_NONE,
        IVR_VK_RESET,
        IVR_VK_SWI,
        IVR_VK_FLAG
    } ivr_vec_kind_t;

endpackage : ivr_pkg

// ==== rtl/ivr_unit.sv ====
// interrupt vector and reset status unit with an AHB-Lite register slave
// assumes sources, cause pulses and the core run on clk_sys
// a small flag cell module at the end holds the repeated register bits
`timescale 1ns/100ps
module ivr_unit (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic ce,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // interrupt sources, bit n is flag n, bit 0 unused
    input wire logic [ivr_pkg::IVR_NUM_SRC:0] srcReq,
    input wire logic swiReq,
    input wire logic rstVecReq,
    // reset cause pulses and the break wait set pulse
    input wire logic pinCause,
    input wire logic watchdogCause,
    input wire logic illegalOpcodeCause,
    input wire logic illegalAddressCause,
    input wire logic modeEntryCause,
    input wire logic lowVoltageCause,
    input wire logic breakWaitSet,
    // vector presented to the core, and the break wait flag
    output logic vecValid,
    output logic [15:0] vecHighAddr,
    output logic [15:0] vecLowAddr,
    output logic [4:0] vecFlag,
    output logic breakWaitFlag
);
    import ivr_pkg::*;

    // ==========================================================
    // state
    // ==========================================================
    // pending and cause bits live in flag cells
    wire logic [7:0] resetCause_q;
    logic breakWait_q;
    logic clearEnable_q;
    wire logic [IVR_NUM_SRC:1] pend_q;
    logic busy_q;
    logic wrPend_q;
    logic [15:0] idx_q;
    logic [31:0] hrdata_q;
    logic hreadyout_q;
    logic hresp_q;
    logic vecValid_q;
    logic [15:0] vecHigh_q;
    logic [15:0] vecLow_q;
    logic [4:0] vecFlag_q;

    // ==========================================================
    // bus decode
    // ==========================================================
    // a transfer is taken when selected, non-idle and the bus is ready
    wire logic takeReq;
    wire logic doWrite;
    wire logic [15:0] reqIdx;
    assign takeReq = hsel & htrans[1] & hready & hreadyout_q & ~busy_q;
    assign reqIdx = haddr[17:2];
    // the write lands at the data phase edge, while busy
    assign doWrite = busy_q & wrPend_q;

    // one select per register index
    wire logic selBreak;
    wire logic selCause;
    wire logic selCtrl;
    wire logic selLow;
    wire logic selHigh;
    assign selBreak = idx_q == IVR_IDX_BREAK_STATUS;
    assign selCause = idx_q == IVR_IDX_RESET_CAUSE;
    assign selCtrl = idx_q == IVR_IDX_BREAK_FLAG_CTRL;
    assign selLow = idx_q == IVR_IDX_PEND_LOW;
    assign selHigh = idx_q == IVR_IDX_PEND_HIGH;

    // ==========================================================
    // register read values
    // ==========================================================
    // sources 6..1 in bits 7..2
    wire logic [7:0] pendLowVal;
    assign pendLowVal = {pend_q[6:1], 2'b00};
    wire logic [7:0] pendHighVal;
    assign pendHighVal = pend_q[14:7];
    // break flag in bit 1, the rest reserved
    wire logic [7:0] breakVal;
    assign breakVal = {6'h00, breakWait_q, 1'b0};
    // clear enable in bit 7, the rest reserved
    wire logic [7:0] ctrlVal;
    assign ctrlVal = {clearEnable_q, 7'h00};

    // unmapped and reserved locations read zero
    wire logic [7:0] rdByte;
    assign rdByte = selBreak ? breakVal :
                    selCause ? {resetCause_q[7:1], 1'b0} :
                    selCtrl ? ctrlVal :
                    selLow ? pendLowVal :
                    selHigh ? pendHighVal : 8'h00;

    // ==========================================================
    // bus handshake: one wait cycle, then data and ready together
    // ==========================================================
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            busy_q <= 1'b0;
            wrPend_q <= 1'b0;
            idx_q <= 16'h0000;
            hreadyout_q <= 1'b1;
            hrdata_q <= 32'h0000_0000;
            hresp_q <= 1'b0;
        end else if (ce) begin
            // every answer is OKAY
            hresp_q <= 1'b0;
            if (takeReq) begin
                busy_q <= 1'b1;
                wrPend_q <= hwrite;
                idx_q <= reqIdx;
                hreadyout_q <= 1'b0;
            end else if (busy_q) begin
                busy_q <= 1'b0;
                hreadyout_q <= 1'b1;
                hrdata_q <= wrPend_q ? 32'h0000_0000 : {24'h000000, rdByte};
            end
        end
    end

    // ==========================================================
    // break status and break flag control
    // ==========================================================
    // zero written to the flag clears it, a set in the same cycle wins
    wire logic breakClr;
    assign breakClr = doWrite & selBreak & ~hwdata[IVR_BIT_BREAK_WAIT];

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            breakWait_q <= 1'b0;
            clearEnable_q <= 1'b0;
        end else if (ce) begin
            if (breakWaitSet) begin
                breakWait_q <= 1'b1;
            end else if (breakClr) begin
                breakWait_q <= 1'b0;
            end
            if (doWrite & selCtrl) begin
                clearEnable_q <= hwdata[IVR_BIT_CLEAR_ENABLE];
            end
        end
    end

    // ==========================================================
    // reset cause recording
    // ==========================================================
    // a cause pulse replaces the record; writes are ignored
    wire logic [7:0] causeHit;
    assign causeHit = {1'b0, pinCause, watchdogCause, illegalOpcodeCause,
                       illegalAddressCause, modeEntryCause, lowVoltageCause,
                       1'b0};

    // one cell per bit; any cause pulse reloads the whole record
    wire logic anyCause;
    assign anyCause = causeHit != 8'h00;

    for (genvar b = 0; b < 8; b++) begin : g_cause
        ivr_flag_cell #(
            .RST_VAL(IVR_RST_RESET_CAUSE[b])
        ) cause_u (
            .clk_sys(clk_sys),
            .rst(rst),
            .ce(ce),
            .load(anyCause),
            .value_d(causeHit[b]),
            .value_q(resetCause_q[b])
        );
    end

    // ==========================================================
    // pending flags
    // ==========================================================
    // flags follow their sources, cleared by reset
    // pending bits load on every enabled edge
    for (genvar n = 1; n <= IVR_NUM_SRC; n++) begin : g_pend
        ivr_flag_cell #(
            .RST_VAL(1'b0)
        ) pend_u (
            .clk_sys(clk_sys),
            .rst(rst),
            .ce(ce),
            .load(1'b1),
            .value_d(srcReq[n]),
            .value_q(pend_q[n])
        );
    end

    // ==========================================================
    // priority selection and vector address
    // ==========================================================
    // lowest flag number has the highest vector, so it wins
    logic [4:0] winFlag;
    logic winAny;
    always_comb begin
        winFlag = 5'd0;
        winAny = 1'b0;
        for (int n = IVR_NUM_SRC; n >= 1; n--) begin
            if (pend_q[n]) begin
                winFlag = 5'(n);
                winAny = 1'b1;
            end
        end
    end

    // flag n vectors at FFFC - 2n; the table keeps each source visible
    logic [15:0] flagVec;
    always_comb begin
        flagVec = IVR_VEC_IDLE;
        case (winFlag)
            // external request lines
            5'd1: flagVec = 16'hFFFA;
            5'd2: flagVec = 16'hFFF8;
            // clock unit
            5'd3: flagVec = 16'hFFF6;
            5'd4: flagVec = 16'hFFF4;
            5'd5: flagVec = 16'hFFF2;
            5'd6: flagVec = 16'hFFF0;
            5'd7: flagVec = 16'hFFEE;
            5'd8: flagVec = 16'hFFEC;
            5'd9: flagVec = 16'hFFEA;
            5'd10: flagVec = 16'hFFE8;
            // first async serial error, receive, transmit
            5'd11: flagVec = 16'hFFE6;
            5'd12: flagVec = 16'hFFE4;
            5'd13: flagVec = 16'hFFE2;
            // keyboard
            5'd14: flagVec = 16'hFFE0;
            5'd15: flagVec = 16'hFFDE;
            5'd16: flagVec = 16'hFFDC;
            5'd17: flagVec = 16'hFFDA;
            5'd18: flagVec = 16'hFFD8;
            5'd19: flagVec = 16'hFFD6;
            5'd20: flagVec = 16'hFFD4;
            // time base module
            5'd21: flagVec = 16'hFFD2;
            default: flagVec = IVR_VEC_IDLE;
        endcase
    end

    // reset first, then software interrupt, then the flags
    ivr_vec_kind_t kind;
    assign kind = rstVecReq ? IVR_VK_RESET :
                  swiReq ? IVR_VK_SWI :
                  winAny ? IVR_VK_FLAG : IVR_VK_NONE;

    // address of the high byte of the winning vector
    logic [15:0] nextVec;
    always_comb begin
        case (kind)
            IVR_VK_RESET: nextVec = IVR_VEC_RESET;
            IVR_VK_SWI: nextVec = IVR_VEC_SWI;
            IVR_VK_FLAG: nextVec = flagVec;
            default: nextVec = IVR_VEC_IDLE;
        endcase
    end

    // vector outputs registered
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            vecValid_q <= 1'b0;
            vecHigh_q <= IVR_VEC_IDLE;
            vecLow_q <= IVR_VEC_IDLE;
            vecFlag_q <= 5'd0;
        end else if (ce) begin
            vecValid_q <= kind != IVR_VK_NONE;
            // the pair is registered together so it never splits
            vecHigh_q <= nextVec;
            vecLow_q <= (kind != IVR_VK_NONE) ? (nextVec | 16'h0001) :
                        IVR_VEC_IDLE;
            vecFlag_q <= (kind == IVR_VK_FLAG) ? winFlag : 5'd0;
        end
    end

    // ==========================================================
    // outputs
    // ==========================================================
    assign hrdata = hrdata_q;
    assign hreadyout = hreadyout_q;
    assign hresp = hresp_q;
    assign vecValid = vecValid_q;
    // high byte at even address, low byte at the next odd one
    assign vecHighAddr = vecHigh_q;
    // low byte address comes from its own flop
    assign vecLowAddr = vecLow_q;
    assign vecFlag = vecFlag_q;
    assign breakWaitFlag = breakWait_q;

endmodule : ivr_unit

// ==========================================================
// one flag bit, frozen while ce is low
// ==========================================================
module ivr_flag_cell #(
    parameter logic RST_VAL = 1'b0
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic ce,
    input wire logic load,
    input wire logic value_d,
    output logic value_q
);
    // load high takes value_d at the next enabled edge
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            value_q <= RST_VAL;
        end else if (ce && load) begin
            value_q <= value_d;
        end
    end
endmodule : ivr_flag_cell

// ==== sim/ivr_unit_asserts.sv ====
// checker on the vector unit ports
// assumes one clock domain and a single bus master
`timescale 1ns/100ps
module ivr_unit_asserts (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic ce,
    input wire logic hsel,
    input wire logic [1:0] htrans,
    input wire logic hready,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic [ivr_pkg::IVR_NUM_SRC:0] srcReq,
    input wire logic swiReq,
    input wire logic rstVecReq,
    input wire logic breakWaitSet,
    input wire logic vecValid,
    input wire logic [15:0] vecHighAddr,
    input wire logic [15:0] vecLowAddr,
    input wire logic [4:0] vecFlag,
    input wire logic breakWaitFlag
);
    import ivr_pkg::*;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);
    // a bus request taken this edge
    wire logic busTake = ce && hsel && htrans[1] && hready && hreadyout;
    // ==========================================================
    // vector checks
    // ==========================================================
    low_pair_a: assert property (
        vecValid |-> vecLowAddr == (vecHighAddr | 16'h0001) &&
        !vecHighAddr[0]) else $error("vector pair not even/odd");
    idle_vec_a: assert property (!vecValid |-> vecLowAddr == 16'h0000 &&
        vecFlag == 5'd0) else $error("idle vector not zero");
    reset_first_a: assert property (
        ce && rstVecReq |=> vecValid && vecHighAddr == 16'hFFFE)
        else $error("reset vector not served first");
    swi_next_a: assert property (
        ce && swiReq && !rstVecReq |=> vecHighAddr == 16'hFFFC)
        else $error("software vector not served");
    flag_addr_a: assert property (
        vecValid && vecFlag != 5'd0 |->
        vecHighAddr == (16'hFFFC - {10'h000, vecFlag, 1'b0}))
        else $error("flag vector address wrong");
    two_wire_a: assert property (
        (ce && srcReq == 22'h000400 && !swiReq && !rstVecReq) [*3] |->
        vecFlag == 5'd10 && vecHighAddr == 16'hFFE8)
        else $error("two-wire vector wrong");
    // ==========================================================
    // bus and break checks
    // ==========================================================
    bus_wait_a: assert property (busTake |=> !hreadyout ##1 hreadyout)
        else $error("bus answer timing wrong");
    okay_resp_a: assert property (hresp == 1'b0)
        else $error("response not okay");
    break_set_a: assert property (
        ce && breakWaitSet |=> breakWaitFlag)
        else $error("break wait flag not set");
    cover property (busTake);
    cover property (vecValid && vecFlag == 5'd10);
    cover property (rstVecReq ##1 vecHighAddr == 16'hFFFE);
endmodule : ivr_unit_asserts
bind ivr_unit ivr_unit_asserts ivr_chk_u (.clk_sys, .rst, .ce, .hsel,
    .htrans, .hready, .hreadyout, .hresp, .srcReq, .swiReq, .rstVecReq,
    .breakWaitSet, .vecValid, .vecHighAddr, .vecLowAddr, .vecFlag,
    .breakWaitFlag);

// ==== sim/ivr_core_model.sv ====
// core side model: fetches the presented vector pair
// assumes vector outputs registered on clk_sys
`timescale 1ns/100ps
module ivr_core_model (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic vecValid,
    input wire logic [15:0] vecHighAddr,
    input wire logic [15:0] vecLowAddr,
    output logic [15:0] fetched
);
    // take the winning pair, odd marker if pair is broken
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            fetched <= 16'h0000;
        end else if (vecValid) begin
            fetched <= (vecLowAddr == (vecHighAddr | 16'h0001)) ?
                vecHighAddr : 16'h0001;
        end
    end
endmodule : ivr_core_model

// ==== sim/interrupt_vector_and_reset_status_test.sv ====
// bench for the vector unit: bus register tests and vector table
// assumes ivr_unit, the core model and the bound checker
`timescale 1ns/100ps
module interrupt_vector_and_reset_status_test;
    import ivr_pkg::*;
    logic clk_sys, rst = 1'b0, hsel = 1'b0, hwrite = 1'b0, bwSet = 1'b0;
    logic ce = 1'b1;
    logic swiReq = 1'b0, rstVecReq = 1'b0, hreadyout, hresp, vecValid;
    logic [31:0] haddr = '0, hwdata = '0, hrdata, rd;
    logic [1:0] htrans = 2'b00;
    logic [21:0] srcReq = '0;
    logic [5:0] cause = '0;
    logic [15:0] vecHighAddr, vecLowAddr, fetched;
    logic [4:0] vecFlag;
    logic breakWaitFlag;
    int mismatches = 0, n_compared = 0;
    ivr_unit dut_u (.clk_sys, .rst, .ce, .hsel, .haddr, .htrans,
        .hwrite, .hsize(3'b010), .hwdata, .hready(hreadyout), .hrdata,
        .hreadyout, .hresp, .srcReq, .swiReq, .rstVecReq,
        .pinCause(cause[5]), .watchdogCause(cause[4]),
        .illegalOpcodeCause(cause[3]), .illegalAddressCause(cause[2]),
        .modeEntryCause(cause[1]), .lowVoltageCause(cause[0]),
        .breakWaitSet(bwSet), .vecValid, .vecHighAddr, .vecLowAddr,
        .vecFlag, .breakWaitFlag);
    ivr_core_model core_u (.clk_sys, .rst, .vecValid, .vecHighAddr,
        .vecLowAddr, .fetched);
    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] s);
        n_compared++;
        if (s !== e) begin
            mismatches++;
            $display("MISMATCH %s expected %h seen %h", nm, e, s);
        end
    endtask : chk
    // one single word transfer, waits on hready both phases
    task automatic bus(input logic wr, input logic [15:0] idx,
                       input logic [31:0] wd);
        @(posedge clk_sys);
        hsel <= 1'b1;
        htrans <= 2'b10;
        hwrite <= wr;
        haddr <= {14'h0000, idx, 2'b00};
        do @(posedge clk_sys); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= wd;
        do @(posedge clk_sys); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask : bus
    task automatic rreg(input logic [15:0] idx, input logic [31:0] e);
        bus(1'b0, idx, 32'h0);
        chk($sformatf("reg %h", idx), e, rd);
        chk("hresp", 32'h0, {31'h0, hresp});
    endtask : rreg
    // wait for pending, vector and fetch to settle
    task automatic vchk(input logic [15:0] a, input logic [4:0] f);
        repeat (4) @(posedge clk_sys);
        chk("valid", 32'h1, {31'h0, vecValid});
        chk("vector", {16'h0, a}, {16'h0, vecHighAddr});
        chk("low", {16'h0, a | 16'h1}, {16'h0, vecLowAddr});
        chk("flag", {27'h0, f}, {27'h0, vecFlag});
        chk("fetched", {16'h0, a}, {16'h0, fetched});
    endtask : vchk
    task automatic complete_run;
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : complete_run
    initial begin
        clk_sys = 1'b0;
        forever #2 clk_sys = ~clk_sys;
    end
    initial begin
        #40000;
        mismatches++;
        complete_run();
    end
    initial begin
        rst <= 1'b1;
        repeat (16) @(posedge clk_sys);
        rst <= 1'b0;
        rreg(IVR_IDX_RESET_CAUSE, 32'h80);
        rreg(IVR_IDX_PEND_LOW, 32'h00);
        bus(1'b1, IVR_IDX_PEND_HIGH, 32'hFF);
        rreg(IVR_IDX_PEND_HIGH, 32'h00);
        bus(1'b1, IVR_IDX_RESET_CAUSE, 32'h00);
        rreg(IVR_IDX_RESET_CAUSE, 32'h80);
        rreg(16'hFE02, 32'h00);
        $display("test reset values done");
        srcReq <= 22'h3FFFFE;
        vchk(16'hFFFA, 5'd1);
        swiReq <= 1'b1;
        vchk(16'hFFFC, 5'd0);
        rstVecReq <= 1'b1;
        vchk(16'hFFFE, 5'd0);
        rstVecReq <= 1'b0;
        swiReq <= 1'b0;
        $display("test priority done");
        for (int n = 1; n <= 21; n++) begin
            srcReq <= 22'h1 << n;
            vchk(16'hFFFC - 16'(2 * n), 5'(n));
            rreg(IVR_IDX_PEND_LOW, n <= 6 ? 32'h1 << (n + 1) : 32'h0);
            rreg(IVR_IDX_PEND_HIGH, (n >= 7 && n <= 14) ?
                32'h1 << (n - 7) : 32'h0);
        end
        srcReq <= '0;
        repeat (3) @(posedge clk_sys);
        chk("idle valid", 32'h0, {31'h0, vecValid});
        $display("test vector table done");
        for (int i = 0; i < 6; i++) begin
            cause <= 6'h01 << i;
            @(posedge clk_sys);
            cause <= 6'h00;
            rreg(IVR_IDX_RESET_CAUSE, {24'h0, 1'b0, 6'h01 << i, 1'b0});
        end
        // a second reset brings back the power-on record
        rst <= 1'b1;
        repeat (16) @(posedge clk_sys);
        rst <= 1'b0;
        rreg(IVR_IDX_RESET_CAUSE, 32'h80);
        $display("test reset causes done");
        bwSet <= 1'b1;
        @(posedge clk_sys);
        bwSet <= 1'b0;
        rreg(IVR_IDX_BREAK_STATUS, 32'h02);
        chk("break flag", 32'h1, {31'h0, breakWaitFlag});
        bus(1'b1, IVR_IDX_BREAK_FLAG_CTRL, 32'h80);
        rreg(IVR_IDX_BREAK_FLAG_CTRL, 32'h80);
        bus(1'b1, IVR_IDX_BREAK_STATUS, 32'hFF);
        rreg(IVR_IDX_BREAK_STATUS, 32'h02);
        bus(1'b1, IVR_IDX_BREAK_STATUS, 32'h00);
        rreg(IVR_IDX_BREAK_STATUS, 32'h00);
        // ce low freezes the flag against a set pulse
        ce <= 1'b0;
        bwSet <= 1'b1;
        @(posedge clk_sys);
        ce <= 1'b1;
        bwSet <= 1'b0;
        @(posedge clk_sys);
        chk("frozen flag", 32'h0, {31'h0, breakWaitFlag});
        $display("test break flag done");
        complete_run();
    end
endmodule : interrupt_vector_and_reset_status_test
